// *** rtl/pmu_seq_pkg.sv ***
// Constants, state encoding and pin indices for the mode sequencer.
// Assumes a single 200 MHz clock that stands in for the internal oscillator.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package pmu_seq_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_KHZ         = 200000;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned DEBOUNCE_MS     = 30;
  localparam int unsigned RST_EXTRA_MS    = 30;
  localparam int unsigned STEP_US         = 64;
  localparam int unsigned RELOAD_US       = 500;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned RST_EXTRA_CYC   = RST_EXTRA_MS * CLK_KHZ;
  localparam int unsigned STEP_CYC        = STEP_US * CLK_MHZ;
  localparam int unsigned RELOAD_CYC      = RELOAD_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC      = 6;

  // --------------------------------------------------------------------------
  // Rails and sequence slots
  // --------------------------------------------------------------------------
  localparam int unsigned N_RAILS         = 9;
  localparam int unsigned RAIL_CONV2      = 1;
  localparam int unsigned RAIL_LIN3       = 4;
  localparam int unsigned SLOT_W          = 4;
  localparam logic [3:0]  SLOT_NONE       = 4'h0;
  localparam logic [3:0]  SLOT_MAX        = 4'hF;

  // --------------------------------------------------------------------------
  // Control byte fields and slave addresses
  // --------------------------------------------------------------------------
  localparam int unsigned CTRL_SLEEP_BIT  = 1;
  localparam int unsigned CTRL_VSET_BIT   = 2;
  localparam logic [6:0]  ADDR_MOD_SET1   = 7'h78;
  localparam logic [6:0]  ADDR_MOD_SET2   = 7'h7A;
  localparam logic [6:0]  ADDR_MAIN_SET1  = 7'h79;
  localparam logic [6:0]  ADDR_MAIN_SET2  = 7'h7B;

  // --------------------------------------------------------------------------
  // Synchronised pin vector
  // --------------------------------------------------------------------------
  localparam int unsigned N_PINS          = 11;
  localparam int unsigned PIN_HOLD        = 0;
  localparam int unsigned PIN_REQ         = 1;
  localparam int unsigned PIN_LIN3        = 2;
  localparam int unsigned PIN_VSET        = 3;
  localparam int unsigned PIN_THERM       = 4;
  localparam int unsigned PIN_UNDERVOLTAGE_LOCKOUT        = 5;
  localparam int unsigned PIN_ROLE        = 6;
  localparam int unsigned PIN_SETUP       = 7;
  localparam int unsigned PIN_FAULT       = 8;

  typedef enum logic [6:0] {
    ST_POR      = 7'h01,
    ST_STANDBY  = 7'h02,
    ST_OFF      = 7'h04,
    ST_RELOAD   = 7'h08,
    ST_STARTUP  = 7'h10,
    ST_IDLE     = 7'h20,
    ST_SHUTDOWN = 7'h40
  } mode_t;

endpackage : pmu_seq_pkg

// *** rtl/pin_conditioner.sv ***
// Per-pin three-stage synchroniser with a stability debounce behind it.
// Assumes pins are asynchronous to clk_sys_i and idle low after reset.
`timescale 1ns/100ps
`default_nettype none
module pin_conditioner #(
  parameter int unsigned W       = 1,
  parameter int unsigned DEB_CYC = 2
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  // Pins
  input  wire logic [W-1:0] pin_i,
  // Conditioned levels
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] stable_o
);
  localparam int unsigned CW = $clog2(DEB_CYC + 1);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic          ff1;
      logic          ff2;
      logic          ff3;
      logic [CW-1:0] cnt;

      always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
          ff1 <= 1'b0;
          ff2 <= 1'b0;
          ff3 <= 1'b0;
        end else begin
          ff1 <= pin_i[g];
          ff2 <= ff1;
          ff3 <= ff2;
        end
      end

      // Only a level that two late stages agree on is taken
      always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
          level_o[g] <= 1'b0;
        end else if (ff2 == ff3) begin
          level_o[g] <= ff3;
        end
      end

      // Any return to the old level throws away the partial count
      always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
          cnt         <= '0;
          stable_o[g] <= 1'b0;
        end else if (level_o[g] == stable_o[g]) begin
          cnt <= '0;
        end else if (cnt == CW'(DEB_CYC - 1)) begin
          cnt         <= '0;
          stable_o[g] <= level_o[g];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate
endmodule : pin_conditioner
`default_nettype wire

// *** rtl/pmu_mode_sequencer.sv ***
// Mode, rail sequencing and reset-output control of the power management unit.
// Assumes register bits arrive as static levels from the serial block's
// register file, and pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
module pmu_mode_sequencer
  import pmu_seq_pkg::*;
#(
  parameter int unsigned N        = N_RAILS,
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
  parameter int unsigned RST_CYC  = RST_EXTRA_CYC,
  parameter int unsigned TICK_CYC = STEP_CYC,
  parameter int unsigned LOAD_CYC = RELOAD_CYC
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  // Shared pins: second converter enable or supply hold, enable or request
  input  wire logic                shared_hold_pin_i,
  input  wire logic                shared_request_pin_i,
  // Other pins and analog indications
  input  wire logic                third_linear_enable_pin_i,
  input  wire logic                voltage_set_select_i,
  input  wire logic                role_strap_i,
  input  wire logic                default_setup_strap_i,
  input  wire logic                thermal_trip_i,
  input  wire logic                undervoltage_lockout_i,
  input  wire logic [2:0]          rail_fault_i,
  // Register bits
  input  wire logic [7:0]          control_reg_i,
  input  wire logic                first_converter_set_one_reg_i,
  input  wire logic [N-1:0]        rail_enable_reg_i,
  input  wire logic [N*SLOT_W-1:0] rail_slot_reg_i,
  input  wire logic [2:0]          rail_fault_mask_i,
  // Rail and reset outputs
  output logic      [N-1:0]        rail_enable_o,
  output logic                     reset_n_o,
  output logic                     first_converter_set_one_o,
  output logic                     sleep_o,
  // Configuration and status
  output logic      [6:0]          slave_address_o,
  output logic                     load_defaults_o,
  output logic                     setup_two_o,
  output logic                     main_role_o,
  output logic                     seq_busy_o,
  output var mode_t                mode_o
);

  // --------------------------------------------------------------------------
  // Pin conditioning
  // --------------------------------------------------------------------------
  localparam int unsigned SW = $clog2(TICK_CYC + 1);
  localparam int unsigned RW = $clog2(RST_CYC + 1);
  localparam int unsigned LW = $clog2(LOAD_CYC + 1);

  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_lvl;
  logic [N_PINS-1:0] pin_deb;

  assign pin_raw = {rail_fault_i, default_setup_strap_i, role_strap_i,
                    undervoltage_lockout_i, thermal_trip_i, voltage_set_select_i,
                    third_linear_enable_pin_i, shared_request_pin_i,
                    shared_hold_pin_i};

  pin_conditioner #(
    .W       (N_PINS),
    .DEB_CYC (DEB_CYC)
  ) u_pins (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_raw),
    .level_o   (pin_lvl),
    .stable_o  (pin_deb)
  );

  logic en;
  logic en_q;
  logic en_rise;
  logic therm;
  logic undervoltage_lockout;
  logic req_deb;
  logic hold_deb;

  assign en       = pin_lvl[PIN_REQ];
  assign therm    = pin_lvl[PIN_THERM];
  assign undervoltage_lockout     = pin_lvl[PIN_UNDERVOLTAGE_LOCKOUT];
  assign req_deb  = pin_deb[PIN_REQ];
  assign hold_deb = pin_deb[PIN_HOLD];
  assign en_rise  = en & ~en_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en;
    end
  end

  // --------------------------------------------------------------------------
  // Declarations for the mode machine
  // --------------------------------------------------------------------------
  mode_t             state;
  logic              role_main;
  logic [2:0]        settle_cnt;
  logic              settle_done;
  logic              therm_seen;
  logic              hold_seen;
  logic [SW-1:0]     step_cnt;
  logic              tick;
  logic [SLOT_W-1:0] cur_step;
  logic [LW-1:0]     load_cnt;
  logic              load_done;
  logic [RW-1:0]     rst_cnt;
  logic              rst_done;
  logic              active;
  logic              stop_req;
  logic              resume;
  mode_t             rest_state;

  assign settle_done = (settle_cnt == 3'(SETTLE_CYC - 1));
  assign load_done   = (load_cnt == LW'(LOAD_CYC - 1));
  assign rst_done    = (rst_cnt == RW'(RST_CYC));
  assign active      = (state == ST_STARTUP) || (state == ST_IDLE) ||
                       (state == ST_SHUTDOWN);
  assign rest_state  = role_main ? ST_OFF : ST_STANDBY;
  assign stop_req    = role_main ? (~hold_deb & ~req_deb) : ~en;
  assign resume      = en_rise | (therm_seen & ~therm & en);

  // --------------------------------------------------------------------------
  // Mode machine
  // --------------------------------------------------------------------------
  // Loss of supply throws the block back to power-on from any mode
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state <= ST_POR;
    end else if (undervoltage_lockout && (state != ST_POR)) begin
      state <= ST_POR;
    end else begin
      case (state)
        ST_POR: begin
          if (settle_done && !undervoltage_lockout) begin
            state <= pin_lvl[PIN_ROLE] ? ST_OFF : ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!role_main && !therm && resume) begin
            state <= ST_STARTUP;
          end
        end
        ST_OFF: begin
          if (req_deb) begin
            state <= ST_RELOAD;
          end
        end
        ST_RELOAD: begin
          if (load_done) begin
            state <= ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (therm) begin
            state <= rest_state;
          end else if (stop_req) begin
            state <= ST_SHUTDOWN;
          end else if (tick && (cur_step == SLOT_MAX)) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (therm) begin
            state <= rest_state;
          end else if (stop_req) begin
            state <= ST_SHUTDOWN;
          end
        end
        ST_SHUTDOWN: begin
          if (therm || (tick && (cur_step == SLOT_NONE))) begin
            state <= rest_state;
          end
        end
        default: begin
          state <= ST_POR;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Straps and defaults
  // --------------------------------------------------------------------------
  // Role is frozen once per power application; strap moves later are ignored
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      settle_cnt <= 3'h0;
      role_main  <= 1'b0;
    end else if (state != ST_POR) begin
      settle_cnt <= 3'h0;
    end else if (!settle_done) begin
      settle_cnt <= settle_cnt + 3'h1;
    end else begin
      role_main <= pin_lvl[PIN_ROLE];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      load_defaults_o <= 1'b0;
      setup_two_o     <= 1'b0;
    end else begin
      load_defaults_o <= ((state == ST_POR) && settle_done && !undervoltage_lockout &&
                          !pin_lvl[PIN_ROLE]) ||
                         ((state == ST_OFF) && req_deb);
      setup_two_o     <= ~pin_lvl[PIN_SETUP];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      load_cnt <= '0;
    end else if (state != ST_RELOAD) begin
      load_cnt <= '0;
    end else if (!load_done) begin
      load_cnt <= load_cnt + 1'b1;
    end
  end

  // Cooling with enable still high restarts; set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      therm_seen <= 1'b0;
    end else if (therm && active) begin
      therm_seen <= 1'b1;
    end else if ((state != ST_STANDBY) || !en) begin
      therm_seen <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Step timer and sequence position
  // --------------------------------------------------------------------------
  assign tick = (step_cnt == SW'(TICK_CYC - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      step_cnt <= '0;
    end else if (((state != ST_STARTUP) && (state != ST_SHUTDOWN)) || tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 1'b1;
    end
  end

  // An aborted startup reverses from the step it had reached
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cur_step <= SLOT_NONE;
    end else begin
      case (state)
        ST_STARTUP: begin
          if (tick && (cur_step != SLOT_MAX)) begin
            cur_step <= cur_step + 4'h1;
          end
        end
        ST_IDLE: begin
          cur_step <= SLOT_MAX;
        end
        ST_SHUTDOWN: begin
          if (tick && (cur_step != SLOT_NONE)) begin
            cur_step <= cur_step - 4'h1;
          end
        end
        default: begin
          cur_step <= SLOT_NONE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Rail enables
  // --------------------------------------------------------------------------
  // Slots are read live, so rewriting them mid-sequence changes the order
  genvar r;
  generate
    for (r = 0; r < N; r++) begin : g_rail
      logic [SLOT_W-1:0] slot;
      logic              in_seq;
      logic              pin_on;

      assign slot = rail_slot_reg_i[r*SLOT_W +: SLOT_W];
      assign in_seq = (state == ST_IDLE) ||
                      (active && (slot != SLOT_NONE) && (slot <= cur_step));
      if (r == RAIL_CONV2) begin : g_pin2
        assign pin_on = ~role_main & pin_lvl[PIN_HOLD];
      end else if (r == RAIL_LIN3) begin : g_pin3
        assign pin_on = pin_lvl[PIN_LIN3];
      end else begin : g_nopin
        assign pin_on = 1'b0;
      end

      // Standby and off leave in_seq low
      always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
          rail_enable_o[r] <= 1'b0;
        end else begin
          rail_enable_o[r] <= in_seq && !therm &&
                              (rail_enable_reg_i[r] || pin_on);
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Reset output
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rst_cnt <= '0;
    end else if (!role_main || !((state == ST_RELOAD) || (state == ST_STARTUP) ||
                                 (state == ST_IDLE))) begin
      rst_cnt <= '0;
    end else if (!rst_done) begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  // Hold only counts once the processor has raised it
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      hold_seen <= 1'b0;
    end else if (role_main && active && hold_deb) begin
      hold_seen <= 1'b1;
    end else if (!active) begin
      hold_seen <= 1'b0;
    end
  end

  logic rst_release;
  logic rst_force;

  assign rst_release = ((state == ST_STARTUP) || (state == ST_IDLE)) &&
                       (role_main ? rst_done : (en & req_deb));
  assign rst_force   = (role_main ? (hold_seen & ~hold_deb) : ~en) |
                       (state == ST_SHUTDOWN) | stop_req | therm |
                       |(pin_lvl[PIN_FAULT +: 3] & ~rail_fault_mask_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reset_n_o <= 1'b0;
    end else begin
      reset_n_o <= rst_release & ~rst_force;
    end
  end

  // --------------------------------------------------------------------------
  // Voltage set, sleep and address
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      first_converter_set_one_o <= 1'b1;
      sleep_o                   <= 1'b0;
    end else begin
      first_converter_set_one_o <= control_reg_i[CTRL_VSET_BIT] ?
                                   first_converter_set_one_reg_i :
                                   pin_lvl[PIN_VSET];
      sleep_o <= control_reg_i[CTRL_SLEEP_BIT] && (state == ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      slave_address_o <= ADDR_MOD_SET1;
    end else begin
      case ({role_main, pin_lvl[PIN_SETUP]})
        2'h0:    slave_address_o <= ADDR_MOD_SET2;
        2'h1:    slave_address_o <= ADDR_MOD_SET1;
        2'h2:    slave_address_o <= ADDR_MAIN_SET2;
        default: slave_address_o <= ADDR_MAIN_SET1;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------------
  assign main_role_o = role_main;
  assign mode_o      = state;
  assign seq_busy_o  = (state == ST_STARTUP) || (state == ST_SHUTDOWN);

endmodule : pmu_mode_sequencer
`default_nettype wire

// *** verif/host_model.sv ***
// Far-side controller: drives enable/request, hold and voltage-set pins.
// Assumes the bench commands levels; pins move only just after an edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock and commands
  input  wire logic clk_sys_i,
  input  wire logic go_i,
  input  wire logic keep_i,
  input  wire logic vsel_i,
  // Pins
  output logic      request_o,
  output logic      hold_o,
  output logic      vset_o
);
  // ---
  // Pin drive
  // ---
  // Vset always at a defined level, never released
  always_ff @(posedge clk_sys_i) begin
    request_o <= go_i;
    hold_o    <= keep_i;
    vset_o    <= vsel_i;
  end
endmodule : host_model
`default_nettype wire

// *** verif/pmu_seq_monitor.sv ***
// Port checker for the mode sequencer, bound to its top module.
// Assumes bench parameter values: debounce 40, reload 10 cycles.
`timescale 1ns/100ps
`default_nettype none
module pmu_seq_monitor
  import pmu_seq_pkg::*;
#(parameter int unsigned N = N_RAILS) (
  input wire logic         clk_sys_i,
  input wire logic         rstn_i,
  input wire logic         shared_request_pin_i,
  input wire logic         voltage_set_select_i,
  input wire logic         thermal_trip_i,
  input wire logic [2:0]   rail_fault_i,
  input wire logic [2:0]   rail_fault_mask_i,
  input wire logic [7:0]   control_reg_i,
  input wire logic [N-1:0] rail_enable_reg_i,
  input wire logic [N-1:0] rail_enable_o,
  input wire logic         reset_n_o,
  input wire logic         first_converter_set_one_o,
  input wire logic         sleep_o,
  input wire logic [6:0]   slave_address_o,
  input wire logic         load_defaults_o,
  input wire logic         setup_two_o,
  input wire logic         main_role_o,
  input wire mode_t        mode_o
);
  // ---
  // Properties
  // ---
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_sleep; sleep_o |-> $past(mode_o) == ST_IDLE && $past(control_reg_i[1]); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without request");
  property p_vset; (!control_reg_i[2] && !voltage_set_select_i)[*7] |=> !first_converter_set_one_o; endproperty
  a_vset: assert property (p_vset) else $error("voltage set ignores pin");
  property p_addr; mode_o == ST_IDLE |-> slave_address_o == {5'h1E, setup_two_o, main_role_o}; endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");
  property p_shut; $rose(mode_o == ST_SHUTDOWN) |-> ##[0:1] !reset_n_o; endproperty
  a_shut: assert property (p_shut) else $error("reset not low at shutdown");
  property p_therm; thermal_trip_i[*8] |=> rail_enable_o == '0; endproperty
  a_therm: assert property (p_therm) else $error("rails on during trip");
  property p_fault; ((rail_fault_i & ~rail_fault_mask_i) != 3'h0)[*8] |=> !reset_n_o; endproperty
  a_fault: assert property (p_fault) else $error("fault left reset high");
  property p_rest; mode_o == ST_STANDBY || mode_o == ST_OFF |-> rail_enable_o == '0; endproperty
  a_rest: assert property (p_rest) else $error("rail on at rest");
  property p_load; $rose(mode_o == ST_RELOAD) |-> load_defaults_o ##1 (mode_o == ST_RELOAD)[*8]; endproperty
  a_load: assert property (p_load) else $error("reload pulse or length wrong");
  property p_loadend; $rose(mode_o == ST_RELOAD) |-> ##[1:40] mode_o == ST_STARTUP; endproperty
  a_loadend: assert property (p_loadend) else $error("reload too long");
  property p_enlow; (!main_role_o && !shared_request_pin_i)[*7] |=> !reset_n_o; endproperty
  a_enlow: assert property (p_enlow) else $error("reset high with enable low");
  property p_or; (mode_o == ST_IDLE && rail_enable_reg_i[RAIL_CONV2])[*2] |-> rail_enable_o[RAIL_CONV2]; endproperty
  a_or: assert property (p_or) else $error("register enable ignored");
  property p_por; $past(mode_o) == ST_POR && mode_o == ST_STANDBY |-> load_defaults_o; endproperty
  a_por: assert property (p_por) else $error("defaults not loaded after power-on");
  c_idle: cover property ($rose(mode_o == ST_IDLE));
  c_load: cover property ($rose(mode_o == ST_RELOAD));
  c_sleep: cover property (sleep_o);
  c_shut: cover property ($rose(mode_o == ST_SHUTDOWN));
endmodule : pmu_seq_monitor
bind pmu_mode_sequencer pmu_seq_monitor #(.N(N)) u_mon (.*);
`default_nettype wire

// *** verif/pmu_mode_sequencer_test.sv ***
// Self-checking bench: module role then main role, shortened counts.
// Assumes the checker is bound; register inputs static during sequences.
`timescale 1ns/100ps
`default_nettype none
module pmu_mode_sequencer_test
  import pmu_seq_pkg::*;
;
  logic clk_sys_i, rstn_i, shared_hold_pin_i, shared_request_pin_i, third_linear_enable_pin_i;
  logic voltage_set_select_i, role_strap_i, default_setup_strap_i, thermal_trip_i;
  logic undervoltage_lockout_i, first_converter_set_one_reg_i, reset_n_o, first_converter_set_one_o;
  logic sleep_o, load_defaults_o, setup_two_o, main_role_o, seq_busy_o, go, keep, vsel;
  logic [2:0] rail_fault_i, rail_fault_mask_i;
  logic [7:0] control_reg_i;
  logic [8:0] rail_enable_reg_i, rail_enable_o;
  logic [35:0] rail_slot_reg_i;
  logic [6:0] slave_address_o;
  mode_t mode_o;
  int errors, comparisons;
  // Short counts keep the run small
  pmu_mode_sequencer #(.DEB_CYC(40), .RST_CYC(40), .TICK_CYC(8), .LOAD_CYC(10)) uut (.*);
  host_model u_host (.clk_sys_i(clk_sys_i), .go_i(go), .keep_i(keep), .vsel_i(vsel),
    .request_o(shared_request_pin_i), .hold_o(shared_hold_pin_i), .vset_o(voltage_set_select_i));
  // ---
  // Helpers
  // ---
  initial begin
    clk_sys_i = 0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test;
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wait_mode(input mode_t m, input int lim);
    while (mode_o !== m && lim > 0) begin
      @(negedge clk_sys_i);
      lim--;
    end
    if (mode_o !== m) begin
      errors++;
      finish_test();
    end
  endtask : wait_mode
  task automatic do_reset(input logic r, input logic s);
    @(posedge clk_sys_i);
    rstn_i <= 0;
    role_strap_i <= r;
    default_setup_strap_i <= s;
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1;
    wait_mode(r ? ST_OFF : ST_STANDBY, 40);
    // Address output settles one edge after the mode; role output changes with it
    @(negedge clk_sys_i);
  endtask : do_reset
  // ---
  // Scenarios
  // ---
  task automatic t_module;
    int t;
    do_reset(0, 1);
    chk("addr", 9'(slave_address_o), 9'h078);
    chk("setup", 9'(setup_two_o), 9'h000);
    chk("role", 9'(main_role_o), 9'h000);
    @(posedge clk_sys_i);
    go <= 1;
    wait_mode(ST_STARTUP, 20);
    chk("rst", 9'(reset_n_o), 9'h000);
    chk("busy", 9'(seq_busy_o), 9'h001);
    wait_mode(ST_IDLE, 300);
    // Unsequenced rails follow one edge after idle is entered
    @(negedge clk_sys_i);
    chk("rails", rail_enable_o, 9'h017);
    chk("rst", 9'(reset_n_o), 9'h001);
    chk("busy", 9'(seq_busy_o), 9'h000);
    @(posedge clk_sys_i);
    control_reg_i <= 8'h02;
    vsel <= 0;
    repeat (9) @(negedge clk_sys_i);
    chk("sleep", 9'(sleep_o), 9'h001);
    chk("vset", 9'(first_converter_set_one_o), 9'h000);
    @(posedge clk_sys_i);
    control_reg_i <= 8'h04;
    thermal_trip_i <= 1;
    wait_mode(ST_STANDBY, 12);
    chk("trip", rail_enable_o, 9'h000);
    chk("vset", 9'(first_converter_set_one_o), 9'h001);
    chk("sleep", 9'(sleep_o), 9'h000);
    @(posedge clk_sys_i);
    thermal_trip_i <= 0;
    wait_mode(ST_STARTUP, 12);
    chk("busy", 9'(seq_busy_o), 9'h001);
    wait_mode(ST_IDLE, 300);
    @(posedge clk_sys_i);
    control_reg_i <= 8'h00;
    go <= 0;
    wait_mode(ST_SHUTDOWN, 20);
    chk("rst", 9'(reset_n_o), 9'h000);
    for (t = 0; rail_enable_o !== 9'h001 && mode_o === ST_SHUTDOWN && t < 200; t++) @(negedge clk_sys_i);
    chk("order", rail_enable_o, 9'h001);
    wait_mode(ST_STANDBY, 300);
    chk("rails", rail_enable_o, 9'h000);
  endtask : t_module
  task automatic t_main;
    int t;
    do_reset(1, 0);
    chk("addr", 9'(slave_address_o), 9'h07B);
    chk("setup", 9'(setup_two_o), 9'h001);
    chk("role", 9'(main_role_o), 9'h001);
    @(posedge clk_sys_i);
    go <= 1;
    keep <= 1;
    for (t = 0; load_defaults_o !== 1 && t < 100; t++) @(negedge clk_sys_i);
    chk("load", {8'h0, load_defaults_o}, 9'h001);
    chk("deb", 9'(t >= 40), 9'h001);
    for (; reset_n_o !== 1 && t < 300; t++) @(negedge clk_sys_i);
    chk("rel", 9'(t >= 80 && t <= 95), 9'h001);
    wait_mode(ST_IDLE, 300);
    @(posedge clk_sys_i);
    rail_fault_i <= 3'h1;
    repeat (8) @(negedge clk_sys_i);
    chk("fault", 9'(reset_n_o), 9'h000);
    @(posedge clk_sys_i);
    rail_fault_i <= 3'h0;
    thermal_trip_i <= 1;
    wait_mode(ST_OFF, 12);
    chk("trip", rail_enable_o, 9'h000);
    @(posedge clk_sys_i);
    undervoltage_lockout_i <= 1;
    wait_mode(ST_POR, 12);
    @(posedge clk_sys_i);
    undervoltage_lockout_i <= 0;
    wait_mode(ST_OFF, 20);
    chk("role", 9'(main_role_o), 9'h001);
  endtask : t_main
  // ---
  // Main sequence
  // ---
  initial begin
    {rstn_i, go, keep, third_linear_enable_pin_i, thermal_trip_i, undervoltage_lockout_i} = '0;
    {role_strap_i, default_setup_strap_i, rail_fault_i, rail_fault_mask_i, control_reg_i} = '0;
    vsel = 1;
    first_converter_set_one_reg_i = 1;
    // Rail registers static from here on: no writes while a sequence runs
    rail_enable_reg_i = 9'h007;
    rail_slot_reg_i = 36'h000000201;
    third_linear_enable_pin_i = 1;
    t_module();
    t_main();
    finish_test();
  end
endmodule : pmu_mode_sequencer_test
`default_nettype wire
